// [rtl/qpm_pkg.sv]
// package for the quadrature phase pin mux: register map, field layout,
// reset values and pin function codes.
// assumes a single 50 MHz core clock and a synchronous active-high reset.
package qpm_pkg;

  // ---------------------------------------------------------------------
  // register bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PIN_SELECT = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_PULLUP = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_SEL = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_GPIO_EN = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_GPIO_DIR = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_GPIO_DATA = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h6;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int PIN_FIRST = 0;
  localparam int PIN_SECOND = 1;
  localparam int NPINS = 2;
  localparam int PERIPH_FLD_W = 2;
  localparam int FN_W = 3;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [NPINS-1:0] PIN_SELECT_RST = 2'h0;
  localparam logic [NPINS-1:0] PULLUP_RST = 2'h3;
  localparam logic [NPINS-1:0] GPIO_RST = 2'h0;
  localparam logic [2*PERIPH_FLD_W-1:0] PERIPH_RST_DEC = 4'h5;
  localparam logic [2*PERIPH_FLD_W-1:0] PERIPH_RST_NONE = 4'h0;

  // ---------------------------------------------------------------------
  // peripheral select field codes
  // ---------------------------------------------------------------------
  localparam logic [PERIPH_FLD_W-1:0] PSEL_NONE = 2'h0;
  localparam logic [PERIPH_FLD_W-1:0] PSEL_DECODER = 2'h1;
  localparam logic [PERIPH_FLD_W-1:0] PSEL_TIMER = 2'h2;

  // ---------------------------------------------------------------------
  // active function of a pin
  // ---------------------------------------------------------------------
  typedef enum logic [FN_W-1:0] {
    FN_NONE,
    FN_DECODER,
    FN_TIMER,
    FN_SERIAL,
    FN_GPIO
  } qpm_fn_t;

endpackage

// [rtl/qpm_sync.sv]
// two-stage synchroniser for pin levels entering the core clock domain.
// assumes its inputs are asynchronous levels, not pulses.
`timescale 1ns/1ps
module qpm_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // asynchronous levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } qpm_sync_state_t;

  qpm_sync_state_t state_ff;
  qpm_sync_state_t nxt_state;

  // meta is read only by the second stage
  always_comb begin
    nxt_state.meta = async_in;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;

endmodule // qpm_sync

// [rtl/qpm_pin_cell.sv]
// steering for one multiplexed pin: output, enable and input fan-out.
// assumes pin_in is already synchronised; purely combinational.
`timescale 1ns/1ps
module qpm_pin_cell (
  input wire qpm_pkg::qpm_fn_t fn, // active function of the pin
  input wire logic serial_master, // serial core in master mode
  input wire logic serial_out, // serial core drive value
  input wire logic timer_out, // timer channel drive value
  input wire logic timer_oe, // timer channel drives
  input wire logic gpio_dir, // 1 = port bit is an output
  input wire logic gpio_dout, // port bit drive value
  input wire logic pin_in, // synchronised pin level
  output logic pin_out, // level to drive
  output logic pin_oe, // pin driven
  output logic to_decoder, // level to the decoder
  output logic to_timer, // level to the timer channel
  output logic to_serial, // level to the serial core
  output logic to_gpio // level to the port bit
);

  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    to_decoder = 1'b0;
    to_timer = 1'b0;
    to_serial = 1'b0;
    to_gpio = 1'b0;
    unique case (fn)
      qpm_pkg::FN_DECODER: begin
        to_decoder = pin_in; // R10
      end
      qpm_pkg::FN_TIMER: begin
        pin_out = timer_out; // R10
        pin_oe = timer_oe;
        to_timer = pin_in;
      end
      qpm_pkg::FN_SERIAL: begin
        // master drives, slave listens on the same pin
        pin_out = serial_out; // R7
        pin_oe = serial_master; // R7
        to_serial = serial_master ? 1'b0 : pin_in; // R7
      end
      qpm_pkg::FN_GPIO: begin
        pin_out = gpio_dout; // R9
        pin_oe = gpio_dir; // R9
        to_gpio = pin_in;
      end
      qpm_pkg::FN_NONE: begin
        // unconfigured pin stays quiet until software picks a function
      end
      default: begin
      end
    endcase
  end

endmodule // qpm_pin_cell

// [rtl/qpm_pin_mux.sv]
// top of the quadrature phase pin mux: two pins shared by decoder phase
// inputs, timer b channels, serial port b and port c bits.
// assumes one core clock, synchronous reset, and a plain register port
// whose read data are expected one cycle after the read strobe.
//
// How it works
// [R1] Setting the first pin's serial select bit routes it to serial clock.
// [R2] Setting the second pin's serial select bit routes it to data out.
// [R3] With the decoder present, reset puts phase A on pin one, B on pin two.
// [R4] Without the decoder, reset leaves both pins unassigned for software.
// [R5] Clearing pull-up enable bit 0 turns off the first pin's pull-up.
// [R6] Clearing pull-up enable bit 1 turns off the second pin's pull-up.
// [R7] As serial clock the first pin drives in master mode, listens as slave.
// [R8] The serial master's data leads its sampling clock edge by half a cycle.
// [R9] A port pin has its own direction bit, free of the other port bits.
// [R10] Without serial or port use, a pin serves its decoder or timer role.
`timescale 1ns/1ps
module qpm_pin_mux #(
  parameter bit HAS_DECODER = 1'b1 // device variant with decoder
) (
  input wire logic core_clk, // core clock, 50 MHz
  input wire logic rst, // synchronous reset, active high
  // register port
  input wire logic [qpm_pkg::ADDR_W-1:0] reg_addr, // register offset
  input wire logic [qpm_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [qpm_pkg::DATA_W-1:0] reg_rdata, // read data, next cycle
  // pins
  input wire logic [qpm_pkg::NPINS-1:0] pin_in, // pin levels, async
  output logic [qpm_pkg::NPINS-1:0] pin_out, // pin drive values
  output logic [qpm_pkg::NPINS-1:0] pin_oe, // pin drive enables
  output logic [qpm_pkg::NPINS-1:0] pin_pullup_en, // pull-up enables
  // decoder core
  output logic decoder_phase_a_in, // phase a to the decoder
  output logic decoder_phase_b_in, // phase b to the decoder
  // timer b core
  input wire logic timer_b_channel_zero_out, // channel 0 drive
  input wire logic timer_b_channel_zero_oe, // channel 0 drives
  output logic timer_b_channel_zero_in, // channel 0 input
  input wire logic timer_b_channel_one_out, // channel 1 drive
  input wire logic timer_b_channel_one_oe, // channel 1 drives
  output logic timer_b_channel_one_in, // channel 1 input
  // serial port b core
  input wire logic serial_port_b_master, // 1 = master mode
  input wire logic serial_port_b_clock_out, // clock from the core
  output logic serial_port_b_clock_in, // clock to the core
  input wire logic serial_port_b_master_out, // data from the core
  output logic serial_port_b_master_in // slave data to the core
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  localparam int NP = qpm_pkg::NPINS;
  localparam int PW = qpm_pkg::PERIPH_FLD_W;
  localparam int FW = qpm_pkg::FN_W;
  localparam int DW = qpm_pkg::DATA_W;

  typedef struct packed {
    logic [NP-1:0] pin_select_register;
    logic [NP-1:0] port_c_pullup_enable;
    logic [2*PW-1:0] periph_sel;
    logic [NP-1:0] gpio_en;
    logic [NP-1:0] gpio_dir;
    logic [NP-1:0] gpio_dout;
    logic [DW-1:0] rdata;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe;
    logic phase_a;
    logic phase_b;
    logic [NP-1:0] timer_in;
    logic serial_clk_in;
    logic serial_data_in;
  } qpm_state_t;

  qpm_state_t state_ff;
  qpm_state_t nxt_state;

  logic [NP-1:0] pin_sync;
  qpm_pkg::qpm_fn_t fn [NP];
  logic [NP-1:0] cell_out;
  logic [NP-1:0] cell_oe;
  logic [NP-1:0] cell_dec;
  logic [NP-1:0] cell_tmr;
  logic [NP-1:0] cell_ser;
  logic [NP-1:0] cell_gpio;
  logic [NP-1:0] serial_drive;
  logic [NP-1:0] timer_drive;
  logic [NP-1:0] timer_en;
  logic [DW-1:0] rd_mux;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  qpm_sync #(
    .WIDTH(NP)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ---------------------------------------------------------------------
  // function selection
  // ---------------------------------------------------------------------
  // serial select beats port use, port use beats decoder or timer
  function automatic qpm_pkg::qpm_fn_t pick_fn(
    input logic alt,
    input logic gpio,
    input logic [PW-1:0] psel
  );
    qpm_pkg::qpm_fn_t f;
    f = qpm_pkg::FN_NONE;
    if (alt) begin
      f = qpm_pkg::FN_SERIAL;
    end else if (gpio) begin
      f = qpm_pkg::FN_GPIO;
    end else if (psel == qpm_pkg::PSEL_DECODER) begin
      f = qpm_pkg::FN_DECODER;
    end else if (psel == qpm_pkg::PSEL_TIMER) begin
      f = qpm_pkg::FN_TIMER;
    end
    return f;
  endfunction

  // both pins of the serial port share the same path depth, so the
  // half-cycle lead of data over clock survives the mux
  assign serial_drive[qpm_pkg::PIN_FIRST] = serial_port_b_clock_out; // R8
  assign serial_drive[qpm_pkg::PIN_SECOND] = serial_port_b_master_out; // R8
  assign timer_drive[qpm_pkg::PIN_FIRST] = timer_b_channel_zero_out;
  assign timer_drive[qpm_pkg::PIN_SECOND] = timer_b_channel_one_out;
  assign timer_en[qpm_pkg::PIN_FIRST] = timer_b_channel_zero_oe;
  assign timer_en[qpm_pkg::PIN_SECOND] = timer_b_channel_one_oe;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      // first pin: serial clock; second pin: serial data out
      assign fn[gi] = pick_fn(state_ff.pin_select_register[gi], // R1 R2
                              state_ff.gpio_en[gi],
                              state_ff.periph_sel[gi*PW +: PW]); // R10

      qpm_pin_cell u_cell (
        .fn(fn[gi]),
        .serial_master(serial_port_b_master),
        .serial_out(serial_drive[gi]),
        .timer_out(timer_drive[gi]),
        .timer_oe(timer_en[gi]),
        .gpio_dir(state_ff.gpio_dir[gi]),
        .gpio_dout(state_ff.gpio_dout[gi]),
        .pin_in(pin_sync[gi]),
        .pin_out(cell_out[gi]),
        .pin_oe(cell_oe[gi]),
        .to_decoder(cell_dec[gi]),
        .to_timer(cell_tmr[gi]),
        .to_serial(cell_ser[gi]),
        .to_gpio(cell_gpio[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      qpm_pkg::OFS_PIN_SELECT: begin
        rd_mux[NP-1:0] = state_ff.pin_select_register;
      end
      qpm_pkg::OFS_PULLUP: begin
        rd_mux[NP-1:0] = state_ff.port_c_pullup_enable;
      end
      qpm_pkg::OFS_PERIPH_SEL: begin
        rd_mux[2*PW-1:0] = state_ff.periph_sel;
      end
      qpm_pkg::OFS_GPIO_EN: begin
        rd_mux[NP-1:0] = state_ff.gpio_en;
      end
      qpm_pkg::OFS_GPIO_DIR: begin
        rd_mux[NP-1:0] = state_ff.gpio_dir;
      end
      qpm_pkg::OFS_GPIO_DATA: begin
        // output bits read back what is driven, input bits the pin
        rd_mux[NP-1:0] = (state_ff.gpio_dir & state_ff.gpio_dout) |
                         (~state_ff.gpio_dir & cell_gpio);
      end
      qpm_pkg::OFS_STATUS: begin
        rd_mux[2*FW-1:0] = {fn[qpm_pkg::PIN_SECOND],
                            fn[qpm_pkg::PIN_FIRST]};
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        qpm_pkg::OFS_PIN_SELECT: begin
          nxt_state.pin_select_register = reg_wdata[NP-1:0]; // R1 R2
        end
        qpm_pkg::OFS_PULLUP: begin
          nxt_state.port_c_pullup_enable = reg_wdata[NP-1:0]; // R5 R6
        end
        qpm_pkg::OFS_PERIPH_SEL: begin
          nxt_state.periph_sel = reg_wdata[2*PW-1:0]; // R4
        end
        qpm_pkg::OFS_GPIO_EN: begin
          nxt_state.gpio_en = reg_wdata[NP-1:0];
        end
        qpm_pkg::OFS_GPIO_DIR: begin
          nxt_state.gpio_dir = reg_wdata[NP-1:0]; // R9
        end
        qpm_pkg::OFS_GPIO_DATA: begin
          nxt_state.gpio_dout = reg_wdata[NP-1:0];
        end
        default: begin
          // unmapped and read-only offsets ignore writes
        end
      endcase
    end
    // read data last as long as the read strobe, one cycle later; zero otherwise
    nxt_state.rdata = reg_rd ? rd_mux : '0;
    // every pin-facing output is registered to keep glitches off pads
    nxt_state.pin_out = cell_out;
    nxt_state.pin_oe = cell_oe; // R7
    nxt_state.phase_a = cell_dec[qpm_pkg::PIN_FIRST]; // R3
    nxt_state.phase_b = cell_dec[qpm_pkg::PIN_SECOND]; // R3
    nxt_state.timer_in = cell_tmr;
    nxt_state.serial_clk_in = cell_ser[qpm_pkg::PIN_FIRST]; // R7
    nxt_state.serial_data_in = cell_ser[qpm_pkg::PIN_SECOND]; // R8
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.pin_select_register <= qpm_pkg::PIN_SELECT_RST;
      state_ff.port_c_pullup_enable <= qpm_pkg::PULLUP_RST; // R5 R6
      // variant decides whether pins come up as decoder phases
      state_ff.periph_sel <= HAS_DECODER ? qpm_pkg::PERIPH_RST_DEC
                                         : qpm_pkg::PERIPH_RST_NONE; // R3 R4
      state_ff.gpio_en <= qpm_pkg::GPIO_RST;
      state_ff.gpio_dir <= qpm_pkg::GPIO_RST;
      state_ff.gpio_dout <= qpm_pkg::GPIO_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign reg_rdata = state_ff.rdata;
  assign pin_out = state_ff.pin_out;
  assign pin_oe = state_ff.pin_oe;
  assign pin_pullup_en = state_ff.port_c_pullup_enable; // R5 R6
  assign decoder_phase_a_in = state_ff.phase_a;
  assign decoder_phase_b_in = state_ff.phase_b;
  assign timer_b_channel_zero_in = state_ff.timer_in[qpm_pkg::PIN_FIRST];
  assign timer_b_channel_one_in = state_ff.timer_in[qpm_pkg::PIN_SECOND];
  assign serial_port_b_clock_in = state_ff.serial_clk_in;
  assign serial_port_b_master_in = state_ff.serial_data_in;

endmodule // qpm_pin_mux

// [tb/qpm_pin_mux_assertions.sv]
// checker for the pin mux top; shadows the register file from bus writes.
// assumes it is bound to every qpm_pin_mux instance.
`timescale 1ns/1ps
module qpm_pin_mux_assertions #(
  parameter bit HAS_DECODER = 1'b1 // variant under watch
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic [qpm_pkg::ADDR_W-1:0] reg_addr, // offset
  input wire logic [qpm_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [qpm_pkg::DATA_W-1:0] reg_rdata, // read data
  input wire logic [qpm_pkg::NPINS-1:0] pin_in, // pin levels
  input wire logic [qpm_pkg::NPINS-1:0] pin_out, // drive values
  input wire logic [qpm_pkg::NPINS-1:0] pin_oe, // drive enables
  input wire logic [qpm_pkg::NPINS-1:0] pin_pullup_en, // pull-ups
  input wire logic decoder_phase_a_in, // phase a
  input wire logic timer_b_channel_one_oe, // channel 1 drives
  input wire logic serial_port_b_master, // master mode
  input wire logic serial_port_b_clock_out, // core clock out
  input wire logic serial_port_b_clock_in, // clock to core
  input wire logic serial_port_b_master_out // core data out
);
  // ----------------------------------------------------------------------
  // register shadow
  // ----------------------------------------------------------------------
  logic [15:0] sh_ff [0:5];
  logic [1:0] sel, pu, gen, dir, dout;
  logic [3:0] psel;
  assign sel = sh_ff[0][1:0];
  assign pu = sh_ff[1][1:0];
  assign psel = sh_ff[2][3:0];
  assign gen = sh_ff[3][1:0];
  assign dir = sh_ff[4][1:0];
  assign dout = sh_ff[5][1:0];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) begin
        sh_ff[i] <= 16'h0000;
      end
      sh_ff[1] <= {14'h0000, qpm_pkg::PULLUP_RST};
      sh_ff[2] <= {12'h000, HAS_DECODER ? qpm_pkg::PERIPH_RST_DEC
                                         : qpm_pkg::PERIPH_RST_NONE};
    end else if (reg_wr && reg_addr < 3'h6) begin
      sh_ff[reg_addr] <= reg_wdata;
    end
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_pullup_first: assert property (pin_pullup_en[0] == pu[0])
    else $error("first pin pull-up does not follow its bit");
  chk_pullup_second: assert property (pin_pullup_en[1] == pu[1])
    else $error("second pin pull-up does not follow its bit");
  chk_pullup_read: assert property (
    reg_rd && reg_addr == qpm_pkg::OFS_PULLUP
    |=> reg_rdata == {14'h0000, $past(pu)})
    else $error("pull-up register read back wrong");
  chk_clock_master: assert property (sel[0] |=> pin_oe[0] ==
    $past(serial_port_b_master) && (!pin_oe[0] ||
    pin_out[0] == $past(serial_port_b_clock_out)))
    else $error("serial clock pin not driven as mode asks");
  chk_data_master: assert property (sel[1]
    |=> pin_oe[1] == $past(serial_port_b_master))
    else $error("serial data pin enable wrong");
  chk_clock_slave: assert property ((sel[0] && !serial_port_b_master &&
    $stable(pin_in[0])) [*3] |=> serial_port_b_clock_in == $past(pin_in[0]))
    else $error("slave clock input not taken from first pin");
  chk_serial_pair: assert property (sel == 2'b11 && serial_port_b_master
    |=> pin_out == $past({serial_port_b_master_out,
    serial_port_b_clock_out}))
    else $error("serial clock and data not delayed alike");
  chk_decoder_phase: assert property (
    (psel[1:0] == qpm_pkg::PSEL_DECODER &&
    !sel[0] && !gen[0] && $stable(pin_in[0])) [*3]
    |=> decoder_phase_a_in == $past(pin_in[0]))
    else $error("phase a not routed from first pin");
  chk_timer_drive: assert property (
    psel[3:2] == qpm_pkg::PSEL_TIMER && !sel[1] && !gen[1]
    |=> pin_oe[1] == $past(timer_b_channel_one_oe))
    else $error("timer channel 1 enable not on second pin");
  chk_port_dir: assert property (gen[1] && !sel[1]
    |=> pin_oe[1] == $past(dir[1]))
    else $error("second port bit direction wrong");
  chk_port_data: assert property (gen[0] && dir[0] && !sel[0]
    |=> pin_out[0] == $past(dout[0]))
    else $error("first port bit drive value wrong");
endmodule // qpm_pin_mux_assertions

bind qpm_pin_mux qpm_pin_mux_assertions #(.HAS_DECODER(HAS_DECODER)) chk_i (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
  .decoder_phase_a_in(decoder_phase_a_in),
  .timer_b_channel_one_oe(timer_b_channel_one_oe),
  .serial_port_b_master(serial_port_b_master),
  .serial_port_b_clock_out(serial_port_b_clock_out),
  .serial_port_b_clock_in(serial_port_b_clock_in),
  .serial_port_b_master_out(serial_port_b_master_out));

// [tb/qpm_far_side.sv]
// far side of the two pins: an encoder or plain driver, plus pull-ups.
// assumes the block's pin enables are high while it drives.
`timescale 1ns/1ps
module qpm_far_side (
  input wire logic core_clk, // bench clock
  input wire logic enc_run, // 1 = encoder turning
  input wire logic [3:0] enc_div, // cycles per step, minus one
  input wire logic [1:0] ext_oe, // far side drives the pin
  input wire logic [1:0] ext_val, // level while not turning
  input wire logic [1:0] pin_out, // block drive values
  input wire logic [1:0] pin_oe, // block drive enables
  input wire logic [1:0] pin_pullup_en, // block pull-ups
  output logic [1:0] pin_level // resolved pin levels
);
  logic [1:0] gray_ff = 2'h0;
  logic [3:0] cnt_ff = 4'h0;
  logic [1:0] last_ff = 2'h0;
  logic [1:0] far;
  always_ff @(posedge core_clk) begin
    cnt_ff <= (cnt_ff >= enc_div) ? 4'h0 : cnt_ff + 4'h1;
    if (enc_run && cnt_ff == 4'h0) begin
      gray_ff <= {gray_ff[0], ~gray_ff[1]};
    end
    last_ff <= pin_level;
  end
  assign far = enc_run ? gray_ff : ext_val;
  // a floating line without pull-up flips, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? far[i] :
                     pin_pullup_en[i] ? 1'b1 : ~last_ff[i];
    end
  end
endmodule // qpm_far_side

// [tb/testbench.sv]
// self-checking bench for the pin mux, far-side model on both pins.
// assumes the checker is bound through its own file.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [qpm_pkg::ADDR_W-1:0] reg_addr = 3'h0;
  logic [qpm_pkg::DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [qpm_pkg::DATA_W-1:0] reg_rdata;
  logic [1:0] pin_level, pin_out, pin_oe, pin_pullup_en, d2;
  logic pa, pb, t0i, t1i, sci, smi;
  logic t0o = 1'b0, t0e = 1'b0, t1o = 1'b0, t1e = 1'b0;
  logic master = 1'b0, sco = 1'b0, smo = 1'b0, enc_run = 1'b0;
  logic [3:0] enc_div = 4'h0;
  logic [1:0] ext_oe = 2'h3, ext_val = 2'h0;
  int seed = 37040;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  always #10 core_clk = ~core_clk;

  qpm_pin_mux #(.HAS_DECODER(1'b1)) uut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_level),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .decoder_phase_a_in(pa), .decoder_phase_b_in(pb),
    .timer_b_channel_zero_out(t0o), .timer_b_channel_zero_oe(t0e),
    .timer_b_channel_zero_in(t0i), .timer_b_channel_one_out(t1o),
    .timer_b_channel_one_oe(t1e), .timer_b_channel_one_in(t1i),
    .serial_port_b_master(master), .serial_port_b_clock_out(sco),
    .serial_port_b_clock_in(sci), .serial_port_b_master_out(smo),
    .serial_port_b_master_in(smi));

  qpm_far_side far_i (.core_clk(core_clk), .enc_run(enc_run),
    .enc_div(enc_div), .ext_oe(ext_oe), .ext_val(ext_val),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_level(pin_level));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // hang guard: run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rdc(qpm_pkg::OFS_PULLUP, 16'h0003);
    rdc(qpm_pkg::OFS_PERIPH_SEL, 16'h0005);
    rdc(qpm_pkg::OFS_STATUS, 16'h0009);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      ext_val <= 2'($random(seed));
      wait_n(4);
      check({14'h0000, pb, pa}, {14'h0000, ext_val});
    end
    enc_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      enc_div <= 4'($random(seed));
      wait_n(40);
    end
    enc_run <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      wr(qpm_pkg::OFS_PULLUP, 16'(v));
      wait_n(2);
      check({14'h0000, pin_pullup_en}, 16'(v));
      rdc(qpm_pkg::OFS_PULLUP, 16'(v));
    end
    wr(3'h7, 16'hFFFF);
    wr(qpm_pkg::OFS_STATUS, 16'hFFFF);
    rdc(3'h7, 16'h0000);
    rdc(qpm_pkg::OFS_STATUS, 16'h0009);
    ext_oe <= 2'h0;
    wr(qpm_pkg::OFS_PERIPH_SEL, 16'h000A);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {t0o, t0e, t1o, t1e} <= 4'($random(seed));
      wait_n(1);
      check({pin_oe, pin_out & pin_oe},
            {t1e, t0e, t1o & t1e, t0o & t0e});
    end
    // timer inputs: channels released, far side drives
    {t0e, t1e, ext_oe} <= 4'h3;
    ext_val <= 2'($random(seed));
    wait_n(5);
    check({t1i, t0i}, ext_val);
    wr(qpm_pkg::OFS_GPIO_EN, 16'h0003);
    wr(qpm_pkg::OFS_PIN_SELECT, 16'h0003);
    master <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {smo, sco} <= 2'($random(seed));
      wait_n(1);
      check({pin_oe, pin_out}, {2'b11, smo, sco});
    end
    rdc(qpm_pkg::OFS_STATUS, 16'h001B);
    master <= 1'b0;
    ext_oe <= 2'h3;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      ext_val <= 2'($random(seed));
      wait_n(4);
      check({pin_oe, smi, sci}, {2'b00, ext_val});
    end
    wr(qpm_pkg::OFS_PIN_SELECT, 16'h0000);
    for (int d = 0; d < 4; d++) begin
      d2 = 2'(d);
      ext_oe <= ~d2;
      wr(qpm_pkg::OFS_GPIO_DIR, 16'(d));
      wr(qpm_pkg::OFS_GPIO_DATA, 16'($random(seed)) & 16'h0003);
      wait_n(4);
      check({pin_oe, pin_out & d2}, {d2, reg_wdata[1:0] & d2});
      rdc(qpm_pkg::OFS_GPIO_DATA,
          {14'h0000, (reg_wdata[1:0] & d2) | (ext_val & ~d2)});
    end
    wr(qpm_pkg::OFS_PULLUP, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdc(qpm_pkg::OFS_PULLUP, 16'h0003);
    rdc(qpm_pkg::OFS_STATUS, 16'h0009);
    end_sim();
  end
endmodule // testbench
